// ==== rtl/pet_cfg.svh ====
// Purpose: timing counts, seeds and thresholds of the pattern error tester
// Assumes: 200 MHz system clock, one received bit per RX_VALID pulse
// Notes: included by the pattern source and the top module; the package and the buffer do not include it
`ifndef PET_CFG_SVH
`define PET_CFG_SVH
`define PET_SEC_NS 1000000000
`define PET_CLK_NS 5
`define PET_SEC_CYCLES (`PET_SEC_NS / `PET_CLK_NS)
`define PET_SEED_ALT 24'h555555
`define PET_SEED_ONE8 24'h404040
`define PET_SEED_3IN24 24'h440004
`define PET_SEED_LFSR 24'hFFFFFF
`define PET_QRSS_ZRUN 14
`define PET_LOCK_MATCH 6'd32
`define PET_LOSS_WIN 7'd64
`define PET_LOSS_ERRS 7'd16
`define PET_SES_RATIO 42'd1000
`define PET_RUN_LEN 4'd10
`endif

// ==== rtl/pet_pkg.sv ====
// Purpose: shared types of the pattern error tester
// Assumes: nothing beyond the cfg header
// Notes: mode codes follow declaration order, starting from zero
`default_nettype none
package pet_pkg;
  typedef enum logic [3:0] {
    PET_PAT_OFF,
    PET_PAT_MARK,
    PET_PAT_SPACE,
    PET_PAT_ALT,
    PET_PAT_ONE8,
    PET_PAT_3IN24,
    PET_PAT_QRSS,
    PET_PAT_PSEUDO_RANDOM_ORDER_11,
    PET_PAT_PSEUDO_RANDOM_ORDER_15,
    PET_PAT_PSEUDO_RANDOM_ORDER_20
  } pet_pat_t;
  typedef enum logic {PET_HUNT, PET_LOCKED} pet_lock_t;
  typedef struct packed {
    pet_pat_t pattern;
    logic [31:0] divisor;
  } pet_cfg_t;
  typedef struct packed {
    logic [31:0] bit_error_total;
    logic [31:0] errored_second_count;
    logic [31:0] severe_second_count;
    logic [31:0] consecutive_severe_count;
    logic [31:0] out_of_lock_seconds;
    logic [31:0] elapsed_seconds;
    logic [47:0] bit_total;
  } pet_counts_t;
  typedef struct packed {
    logic [23:0] sr;
  } pet_gen_st_t;
endpackage
`default_nettype wire

// ==== rtl/pet_patgen.sv ====
// Purpose: pattern source shared by the sender and the checker
// Assumes: seed, load and advance are one-cycle strobes
// Notes: load shifts a received bit in, so the checker can self-seed
`timescale 1ns/100ps
`default_nettype none
`include "pet_cfg.svh"
module pet_patgen (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // control
  input var pet_pkg::pet_pat_t mode,
  input wire logic seed,
  input wire logic advance,
  input wire logic load,
  input wire logic load_bit,
  // pattern bit for the current position
  output logic out_bit
);
  import pet_pkg::*;
  pet_gen_st_t st;
  pet_gen_st_t next_st;
  logic raw;
  logic pat;
  logic [23:0] seed_val;

  always_comb
  begin
    raw = 1'b0;
    seed_val = `PET_SEED_LFSR;
    unique case (mode)
      PET_PAT_OFF, PET_PAT_SPACE: raw = 1'b0;
      PET_PAT_MARK: raw = 1'b1;
      PET_PAT_ALT:
      begin
        raw = st.sr[1];
        seed_val = `PET_SEED_ALT;
      end
      PET_PAT_ONE8:
      begin
        raw = st.sr[7];
        seed_val = `PET_SEED_ONE8;
      end
      PET_PAT_3IN24:
      begin
        raw = st.sr[23];
        seed_val = `PET_SEED_3IN24;
      end
      PET_PAT_QRSS: raw = st.sr[19] ^ st.sr[16];
      PET_PAT_PSEUDO_RANDOM_ORDER_11: raw = st.sr[10] ^ st.sr[8];
      PET_PAT_PSEUDO_RANDOM_ORDER_15: raw = st.sr[14] ^ st.sr[13];
      PET_PAT_PSEUDO_RANDOM_ORDER_20: raw = st.sr[19] ^ st.sr[2];
    endcase
    // in QRSS mode long zero runs are forced to one; the register keeps the raw bit
    pat = raw;
    if (mode == PET_PAT_QRSS && st.sr[`PET_QRSS_ZRUN-1:0] == '0)
    begin
      pat = 1'b1;
    end
    next_st = st;
    if (seed)
    begin
      next_st.sr = seed_val;
    end
    else if (load)
    begin
      next_st.sr = {st.sr[22:0], load_bit};
    end
    else if (advance)
    begin
      next_st.sr = {st.sr[22:0], raw};
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      st <= '{sr: `PET_SEED_LFSR};
    end
    else
    begin
      st <= next_st;
    end
  end

  assign out_bit = pat;
endmodule // pet_patgen
`default_nettype wire

// ==== rtl/pet_skid.sv ====
// Purpose: two-entry buffer between pattern source and the framer
// Assumes: out_ready may drop at any cycle
// Notes: outputs come from flops; in_ready is low while both are full
`timescale 1ns/100ps
`default_nettype none
module pet_skid #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // filling side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // draining side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  typedef struct packed {
    logic [WIDTH-1:0] d0;
    logic [WIDTH-1:0] d1;
    logic v0;
    logic v1;
  } pet_buf_st_t;
  pet_buf_st_t st;
  pet_buf_st_t next_st;
  logic push;

  if (WIDTH < 1)
  begin : g_bad_width
    $error("pet_skid WIDTH must be at least 1");
  end

  always_comb
  begin
    next_st = st;
    push = in_valid && !st.v1;
    if (out_ready && st.v0)
    begin
      next_st.d0 = st.d1;
      next_st.v0 = st.v1;
      next_st.v1 = 1'b0;
    end
    if (push)
    begin
      if (!next_st.v0)
      begin
        next_st.d0 = in_data;
        next_st.v0 = 1'b1;
      end
      else
      begin
        next_st.d1 = in_data;
        next_st.v1 = 1'b1;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign in_ready = !st.v1;
  assign out_valid = st.v0;
  assign out_data = st.d0;
endmodule // pet_skid
`default_nettype wire

// ==== rtl/pet_top.sv ====
// Purpose: bit error rate tester for one WAN port
// Assumes: framer adds framing and CRC after TX_BIT leaves here
// Notes: all commands are one-cycle pulses from logic on SYS_CLK
`timescale 1ns/100ps
`default_nettype none
`include "pet_cfg.svh"
module pet_top #(
  parameter logic [31:0] SEC_CYCLES = 32'(`PET_SEC_CYCLES)
) (
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic RESET,
  // settings
  input wire logic PEND_WR,
  input var pet_pkg::pet_cfg_t PEND_IN,
  input wire logic SAVE_CMD,
  input wire logic UNDO_CMD,
  output pet_pkg::pet_cfg_t PENDING,
  output pet_pkg::pet_cfg_t ACTIVE,
  output logic UNSAVED,
  // commands
  input wire logic INSERT_ERR,
  input wire logic CLEAR_CMD,
  input wire logic REFRESH_CMD,
  // transmit stream toward the framer
  output logic TX_BIT,
  output logic TX_VALID,
  input wire logic TX_READY,
  // receive stream from the framer
  input wire logic RX_BIT,
  input wire logic RX_VALID,
  // status
  output logic LOCKED,
  output logic TICK,
  output logic INSERT_PENDING,
  output pet_pkg::pet_counts_t COUNTS,
  output pet_pkg::pet_counts_t SHOWN
);
  import pet_pkg::*;

  typedef struct packed {
    pet_cfg_t pend;
    pet_cfg_t act;
    logic reseed;
    logic [31:0] tick_cnt;
    logic tick;
    logic ins_pend;
    pet_lock_t lock_st;
    logic [5:0] match_cnt;
    logic [6:0] win_cnt;
    logic [6:0] win_err;
    logic [31:0] sec_bits;
    logic [31:0] sec_errs;
    logic sec_unlock;
    logic [3:0] sev_run;
    logic [3:0] clean_run;
    logic consec;
    pet_counts_t cnt;
    pet_counts_t shown;
    logic unsaved;
  } pet_top_st_t;

  pet_top_st_t st;
  pet_top_st_t next_st;

  if (SEC_CYCLES < 32'd2)
  begin : g_bad_sec
    $error("pet_top SEC_CYCLES must be at least 2");
  end

  ////////////////////////////////////////////////////////////////////////
  // pattern sources and the transmit buffer

  logic running;
  logic tx_pat;
  logic tx_push;
  logic buf_ready;
  logic rx_pred;
  logic rx_take;
  logic rx_load;
  logic rx_adv;
  logic tx_word;

  assign running = st.act.pattern != PET_PAT_OFF;
  // hold the source during a reseed so no stale bit is queued
  assign tx_push = running && buf_ready && !st.reseed;
  // flipping the payload before the framer keeps its CRC consistent
  assign tx_word = tx_pat ^ st.ins_pend;
  assign rx_take = running && RX_VALID;
  assign rx_load = rx_take && st.lock_st == PET_HUNT;
  assign rx_adv = rx_take && st.lock_st == PET_LOCKED;

  pet_patgen u_tx_gen (
    .clk(SYS_CLK),
    .rst(RESET),
    .mode(st.act.pattern),
    .seed(st.reseed),
    .advance(tx_push),
    .load(1'b0),
    .load_bit(1'b0),
    .out_bit(tx_pat)
  );

  pet_patgen u_rx_gen (
    .clk(SYS_CLK),
    .rst(RESET),
    .mode(st.act.pattern),
    .seed(st.reseed),
    .advance(rx_adv),
    .load(rx_load),
    .load_bit(RX_BIT),
    .out_bit(rx_pred)
  );

  pet_skid #(
    .WIDTH(1)
  ) u_buf (
    .clk(SYS_CLK),
    .rst(RESET),
    .in_valid(tx_push),
    .in_ready(buf_ready),
    .in_data(tx_word),
    .out_valid(TX_VALID),
    .out_ready(TX_READY),
    .out_data(TX_BIT)
  );

  ////////////////////////////////////////////////////////////////////////
  // next state

  logic mismatch;
  logic err_bit;
  logic tick_now;
  logic unlock_now;
  logic ses_now;
  logic es_now;
  logic next_consec;
  logic [3:0] sev_next;
  logic [3:0] clean_next;
  logic [41:0] err_scaled;
  logic [31:0] div;

  always_comb
  begin
    next_st = st;
    next_st.reseed = 1'b0;
    next_st.tick = 1'b0;
    mismatch = rx_take && (RX_BIT != rx_pred);
    err_bit = mismatch && st.lock_st == PET_LOCKED;
    unlock_now = running && st.lock_st != PET_LOCKED;
    ses_now = 1'b0;
    es_now = 1'b0;
    next_consec = st.consec;
    sev_next = st.sev_run;
    clean_next = st.clean_run;
    err_scaled = 42'(st.sec_errs) * `PET_SES_RATIO;
    div = st.act.divisor;

    // settings: save commits pending, undo restores it
    if (SAVE_CMD)
    begin
      next_st.act = st.pend;
      next_st.reseed = 1'b1;
    end
    if (UNDO_CMD && !SAVE_CMD)
    begin
      next_st.pend = st.act;
    end
    else if (PEND_WR)
    begin
      next_st.pend = PEND_IN;
    end
    next_st.unsaved = next_st.pend != next_st.act;

    // one-second divider; a divisor below two acts as two
    tick_now = (div < 32'd2) ? (st.tick_cnt != '0) : (st.tick_cnt >= div - 32'd1);
    if (tick_now || st.reseed || CLEAR_CMD)
    begin
      next_st.tick_cnt = '0;
    end
    else
    begin
      next_st.tick_cnt = st.tick_cnt + 32'd1;
    end
    next_st.tick = tick_now;

    // error insertion request waits for the next queued bit
    next_st.ins_pend = running && (INSERT_ERR || (st.ins_pend && !tx_push));

    // pattern lock
    unique case (st.lock_st)
      PET_HUNT:
      begin
        if (rx_take)
        begin
          if (mismatch)
          begin
            next_st.match_cnt = '0;
          end
          else if (st.match_cnt == `PET_LOCK_MATCH - 6'd1)
          begin
            next_st.lock_st = PET_LOCKED;
            next_st.match_cnt = '0;
            next_st.win_cnt = '0;
            next_st.win_err = '0;
          end
          else
          begin
            next_st.match_cnt = st.match_cnt + 6'd1;
          end
        end
      end
      PET_LOCKED:
      begin
        if (rx_take)
        begin
          if (st.win_cnt == `PET_LOSS_WIN - 7'd1)
          begin
            if (st.win_err + 7'(mismatch) >= `PET_LOSS_ERRS)
            begin
              next_st.lock_st = PET_HUNT;
            end
            next_st.win_cnt = '0;
            next_st.win_err = '0;
          end
          else
          begin
            next_st.win_cnt = st.win_cnt + 7'd1;
            next_st.win_err = st.win_err + 7'(mismatch);
          end
        end
      end
    endcase
    if (st.reseed || !running)
    begin
      next_st.lock_st = PET_HUNT;
      next_st.match_cnt = '0;
    end

    // running totals
    if (err_bit)
    begin
      next_st.cnt.bit_error_total = st.cnt.bit_error_total + 32'd1;
    end
    if (rx_take)
    begin
      next_st.cnt.bit_total = st.cnt.bit_total + 48'd1;
    end

    // per-second judgement uses the second that just ended
    if (tick_now && running)
    begin
      es_now = st.sec_errs != '0;
      ses_now = err_scaled > 42'(st.sec_bits);
      if (es_now)
      begin
        next_st.cnt.errored_second_count = st.cnt.errored_second_count + 32'd1;
      end
      if (ses_now)
      begin
        next_st.cnt.severe_second_count = st.cnt.severe_second_count + 32'd1;
        clean_next = '0;
        sev_next = (st.sev_run == `PET_RUN_LEN) ? st.sev_run : st.sev_run + 4'd1;
        if (sev_next == `PET_RUN_LEN)
        begin
          next_consec = 1'b1;
        end
      end
      else
      begin
        sev_next = '0;
        clean_next = (st.clean_run == `PET_RUN_LEN) ? st.clean_run : st.clean_run + 4'd1;
        if (clean_next == `PET_RUN_LEN)
        begin
          next_consec = 1'b0;
        end
      end
      if (next_consec)
      begin
        next_st.cnt.consecutive_severe_count = st.cnt.consecutive_severe_count + 32'd1;
      end
      if (st.sec_unlock)
      begin
        next_st.cnt.out_of_lock_seconds = st.cnt.out_of_lock_seconds + 32'd1;
      end
      next_st.cnt.elapsed_seconds = st.cnt.elapsed_seconds + 32'd1;
      next_st.sev_run = sev_next;
      next_st.clean_run = clean_next;
      next_st.consec = next_consec;
    end

    // accumulate the current second; the tick cycle opens a new one
    if (tick_now)
    begin
      next_st.sec_bits = 32'(rx_take);
      next_st.sec_errs = 32'(err_bit);
      next_st.sec_unlock = unlock_now;
    end
    else
    begin
      next_st.sec_bits = st.sec_bits + 32'(rx_take);
      next_st.sec_errs = st.sec_errs + 32'(err_bit);
      next_st.sec_unlock = st.sec_unlock || unlock_now;
    end

    // clear takes precedence over any count in the same cycle
    if (CLEAR_CMD)
    begin
      next_st.cnt = '0;
      next_st.sec_bits = '0;
      next_st.sec_errs = '0;
      next_st.sec_unlock = 1'b0;
      next_st.sev_run = '0;
      next_st.clean_run = '0;
      next_st.consec = 1'b0;
    end

    // displayed copy only moves on refresh or clear
    if (REFRESH_CMD || CLEAR_CMD)
    begin
      next_st.shown = next_st.cnt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge SYS_CLK)
  begin
    if (RESET)
    begin
      st <= '0;
      st.pend <= '{pattern: PET_PAT_OFF, divisor: SEC_CYCLES};
      st.act <= '{pattern: PET_PAT_OFF, divisor: SEC_CYCLES};
      st.lock_st <= PET_HUNT;
    end
    else
    begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs, all straight from the state register

  assign PENDING = st.pend;
  assign ACTIVE = st.act;
  assign UNSAVED = st.unsaved;
  assign LOCKED = st.lock_st == PET_LOCKED;
  assign TICK = st.tick;
  assign INSERT_PENDING = st.ins_pend;
  assign COUNTS = st.cnt;
  assign SHOWN = st.shown;
endmodule // pet_top
`default_nettype wire

// ==== test/pet_top_chk.sv ====
// Purpose: port assertions of the pattern error tester
// Assumes: one clock, synchronous reset high
// Notes: counter checks let a clear win
`timescale 1ns/100ps
`default_nettype none
module pet_top_chk
  import pet_pkg::*;
(
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic RESET,
  // commands and streams
  input wire logic PEND_WR,
  input wire logic SAVE_CMD,
  input wire logic UNDO_CMD,
  input wire logic INSERT_ERR,
  input wire logic CLEAR_CMD,
  input wire logic TX_READY,
  input wire logic RX_VALID,
  // status
  input wire logic TX_BIT,
  input wire logic TX_VALID,
  input wire logic LOCKED,
  input wire logic TICK,
  input wire logic INSERT_PENDING,
  input var pet_cfg_t PENDING,
  input var pet_cfg_t ACTIVE,
  input var pet_counts_t COUNTS
);
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (RESET);
  logic run;
  assign run = ACTIVE.pattern != PET_PAT_OFF;
  ////////////////////////////////////////
  chk_clear_zero: assert property (CLEAR_CMD |=> COUNTS == '0)
    else $error("counters not zero after clear");
  chk_save_commit: assert property (SAVE_CMD |=> ACTIVE == $past(PENDING))
    else $error("save did not commit pending");
  chk_undo_back: assert property (
    UNDO_CMD && !SAVE_CMD && !PEND_WR |=> PENDING == $past(ACTIVE))
    else $error("undo did not restore pending");
  // a stalled head must not move, or a bit is lost
  chk_stall_hold: assert property (
    TX_VALID && !TX_READY && !SAVE_CMD |=> TX_VALID && $stable(TX_BIT))
    else $error("stalled bit changed");
  chk_err_step: assert property (
    !CLEAR_CMD |=> COUNTS.bit_error_total - $past(COUNTS.bit_error_total)
      <= 32'($past(RX_VALID) && $past(LOCKED) && $past(run)))
    else $error("bit errors moved without a locked bit");
  chk_bit_count: assert property (
    RX_VALID && run && !CLEAR_CMD |=> COUNTS.bit_total == $past(COUNTS.bit_total) + 48'h1)
    else $error("received bit not counted");
  chk_sec_tick: assert property (
    $changed(COUNTS.elapsed_seconds) && !$past(CLEAR_CMD) |-> ##[0:1] TICK)
    else $error("seconds moved off the tick");
  chk_severe_es: assert property (
    $changed(COUNTS.severe_second_count) && !$past(CLEAR_CMD)
      |-> $changed(COUNTS.errored_second_count))
    else $error("severe second not errored");
  chk_sec_gate: assert property (
    ($changed(COUNTS.consecutive_severe_count) || $changed(COUNTS.out_of_lock_seconds))
      && !$past(CLEAR_CMD) |-> $changed(COUNTS.elapsed_seconds))
    else $error("second counter moved off a second");
  chk_insert_flag: assert property (INSERT_ERR && run |=> INSERT_PENDING)
    else $error("insert request lost");
  chk_off_unlock: assert property (!run ##1 !run |=> !LOCKED)
    else $error("locked while off");
  cov_lock: cover property ($rose(LOCKED));
  cov_consecutive_severe_count: cover property ($changed(COUNTS.consecutive_severe_count));
  cov_insert: cover property ($fell(INSERT_PENDING));
endmodule // pet_top_chk
bind pet_top pet_top_chk u_chk (
  .SYS_CLK, .RESET, .PEND_WR, .SAVE_CMD, .UNDO_CMD, .INSERT_ERR, .CLEAR_CMD,
  .TX_READY, .RX_VALID, .TX_BIT, .TX_VALID, .LOCKED, .TICK, .INSERT_PENDING,
  .PENDING, .ACTIVE, .COUNTS
);
`default_nettype wire

// ==== test/pet_far_end.sv ====
// Purpose: far-end line looped back toward the tester
// Assumes: bench commands stall, garble and one-bit flips
// Notes: ready is registered, so it lags the stall by a cycle
`timescale 1ns/100ps
`default_nettype none
module pet_far_end (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // bench commands
  input wire logic stall,
  input wire logic garble,
  input wire logic flip_one,
  // stream in and out
  input wire logic tx_bit,
  input wire logic tx_valid,
  output logic tx_ready,
  output logic rx_bit,
  output logic rx_valid
);
  always_ff @(posedge clk)
  begin
    tx_ready <= !rst && !stall;
    rx_valid <= !rst && tx_valid && tx_ready;
    // idle line toggles so a stale bit never looks good
    rx_bit <= rst ? 1'b0 : (tx_valid && tx_ready) ? tx_bit ^ garble ^ flip_one : !rx_bit;
  end
endmodule // pet_far_end
`default_nettype wire

// ==== test/pet_top_bench.sv ====
// Purpose: self-checking bench of the pattern error tester
// Assumes: far-end model loops each sent bit back
// Notes: a 1200-cycle second keeps the run short
`timescale 1ns/100ps
`default_nettype none
module pet_top_bench;
  import pet_pkg::*;
  localparam int SEC = 1200;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic pend_wr = 1'b0, save_cmd = 1'b0, undo_cmd = 1'b0;
  logic ins = 1'b0, clr = 1'b0, refresh = 1'b0;
  logic stall = 1'b0, garble = 1'b0, flip = 1'b0;
  pet_pat_t pat = PET_PAT_OFF;
  pet_cfg_t pend_in = '{PET_PAT_OFF, 32'h4B0};
  pet_cfg_t pending, active;
  pet_counts_t counts, shown;
  logic unsaved, tx_bit, tx_valid, tx_ready, rx_bit, rx_valid, locked, tick, ins_pend;
  logic [23:0] hist = 24'h0;
  logic [16:0] rnd = 17'h15A51;
  pet_pat_t pats[9] = '{PET_PAT_MARK, PET_PAT_SPACE, PET_PAT_ALT, PET_PAT_ONE8,
    PET_PAT_3IN24, PET_PAT_QRSS, PET_PAT_PSEUDO_RANDOM_ORDER_11, PET_PAT_PSEUDO_RANDOM_ORDER_20, PET_PAT_PSEUDO_RANDOM_ORDER_15};
  int ones[9] = '{24, 0, 12, 3, 3, -1, -1, -1, -1};
  // one error stays below the severe ratio, two exceed it
  int errs[31] = '{1, 2, 2, 2, 2, 2, 2, 2, 2, 2, 2, 0, 0, 0, 0, 0, 0, 0, 0, 0, 2,
    0, 0, 0, 0, 0, 0, 0, 0, 0, 0};
  int checks = 0, miscompares = 0, m_bits = 0;
  int m_be = 0, m_es = 0, m_ses = 0, m_cs = 0, m_el = 0, sr = 0, cr = 0;
  bit st = 0, sev;
  pet_top #(.SEC_CYCLES(32'h4B0)) u_dut (
    .SYS_CLK(sys_clk), .RESET(reset), .PEND_WR(pend_wr), .PEND_IN(pend_in),
    .SAVE_CMD(save_cmd), .UNDO_CMD(undo_cmd), .PENDING(pending), .ACTIVE(active),
    .UNSAVED(unsaved), .INSERT_ERR(ins), .CLEAR_CMD(clr), .REFRESH_CMD(refresh),
    .TX_BIT(tx_bit), .TX_VALID(tx_valid), .TX_READY(tx_ready), .RX_BIT(rx_bit),
    .RX_VALID(rx_valid), .LOCKED(locked), .TICK(tick), .INSERT_PENDING(ins_pend),
    .COUNTS(counts), .SHOWN(shown)
  );
  pet_far_end u_far (
    .clk(sys_clk), .rst(reset), .stall(stall), .garble(garble), .flip_one(flip),
    .tx_bit(tx_bit), .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_bit(rx_bit),
    .rx_valid(rx_valid)
  );
  initial forever #2.5 sys_clk = ~sys_clk;
  ////////////////////////////////////////
  always @(posedge sys_clk)
  begin
    if (tx_valid && tx_ready)
      hist <= {hist[22:0], tx_bit};
    if (clr)
      m_bits <= 0;
    else if (rx_valid)
      m_bits <= m_bits + 1;
  end
  function automatic logic [16:0] lfsr(input logic [16:0] v);
    return {v[15:0], v[16] ^ v[13]};
  endfunction
  task automatic check(input logic [47:0] seen, input logic [47:0] want);
    checks++;
    if (seen !== want)
    begin
      miscompares++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, want);
    end
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task automatic cmd(input logic [5:0] m);
    @(posedge sys_clk);
    pend_in <= '{pat, 32'h4B0};
    {pend_wr, save_cmd, undo_cmd, ins, clr, refresh} <= m;
    @(posedge sys_clk);
    {pend_wr, save_cmd, undo_cmd, ins, clr, refresh} <= 6'h00;
    @(negedge sys_clk);
  endtask
  task automatic wait_hi(ref logic s, input int lim);
    int n;
    n = 0;
    @(negedge sys_clk);
    while (s !== 1'b1)
    begin
      n++;
      if (n > lim)
      begin
        miscompares++;
        print_verdict();
      end
      @(negedge sys_clk);
    end
  endtask
  ////////////////////////////////////////
  initial
  begin
    repeat (10) @(posedge sys_clk);
    reset <= 1'b0;
    @(negedge sys_clk);
    check(48'(active), 48'({PET_PAT_OFF, 32'h4B0}));
    check(48'(pending), 48'({PET_PAT_OFF, 32'h4B0}));
    check({locked, tx_valid, unsaved, |counts}, 4'h0);
    foreach (pats[i])
    begin
      pat = pats[i];
      cmd(6'h20);
      check(unsaved, 1'b1);
      cmd(6'h10);
      check({active, unsaved}, {pat, 32'h4B0, 1'b0});
      cyc(5);
      wait_hi(locked, 600);
      cyc(40);
      if (ones[i] >= 0)
        check(48'($countones(hist)), 48'(ones[i]));
    end
    pat = PET_PAT_PSEUDO_RANDOM_ORDER_11;
    cmd(6'h20);
    cmd(6'h08);
    check({pending, unsaved}, {PET_PAT_PSEUDO_RANDOM_ORDER_15, 32'h4B0, 1'b0});
    cmd(6'h02);
    repeat (400)
    begin
      @(posedge sys_clk);
      rnd = lfsr(rnd);
      stall <= rnd[0] & rnd[5];
    end
    stall <= 1'b0;
    cyc(8);
    check({locked, counts.bit_error_total}, {1'b1, 32'h0});
    check(counts.bit_total, 48'(m_bits));
    cmd(6'h01);
    check(shown.bit_total, 48'(m_bits));
    cmd(6'h02);
    foreach (errs[s])
    begin
      repeat (errs[s])
      begin
        cyc(7);
        @(posedge sys_clk) flip <= 1'b1;
        @(posedge sys_clk) flip <= 1'b0;
      end
      wait_hi(tick, 2 * SEC);
      sev = errs[s] * 1000 > SEC;
      sr = sev ? sr + 1 : 0;
      cr = sev ? 0 : cr + 1;
      st = (sr == 10) | (st & (cr != 10));
      m_es += errs[s] > 0;
      m_ses += sev;
      m_cs += st;
      m_be += errs[s];
      m_el++;
      check(counts.errored_second_count, 48'(m_es));
      check(counts.severe_second_count, 48'(m_ses));
      check(counts.consecutive_severe_count, 48'(m_cs));
      check(counts.elapsed_seconds, 48'(m_el));
      check(counts.out_of_lock_seconds, 48'h0);
      check(counts.bit_error_total, 48'(m_be));
      check(counts.bit_total, 48'(m_bits));
    end
    m_be++;
    cmd(6'h04);
    cyc(20);
    check({ins_pend, counts.bit_error_total}, {1'b0, 32'(m_be)});
    // switching off drops lock and drains the line; inserts are refused
    pat = PET_PAT_OFF;
    cmd(6'h20);
    cmd(6'h10);
    cmd(6'h04);
    cyc(5);
    check({locked, tx_valid, ins_pend}, 3'h0);
    // an inverted echo never matches, so every second is out of lock
    pat = PET_PAT_PSEUDO_RANDOM_ORDER_15;
    @(posedge sys_clk) garble <= 1'b1;
    cmd(6'h20);
    cmd(6'h10);
    cmd(6'h02);
    check(shown.bit_total, 48'h0);
    repeat (3) wait_hi(tick, 2 * SEC);
    check({locked, counts.out_of_lock_seconds}, {1'b0, 32'h3});
    check(counts.elapsed_seconds, 48'h3);
    check(shown.elapsed_seconds, 48'h0);
    print_verdict();
  end
endmodule // pet_top_bench
`default_nettype wire
